//--- verilog/wdw_top.sv
// Windowed watchdog with key kick, closed-window check and illegal access check.
`timescale 1ns/1ps
`default_nettype none
`include "wdw_consts.svh"

module wdw_top #(
    parameter int unsigned LSO_DIV = `WDW_LSO_DIV
) (
    input  wire logic             clk_i,       // System clock, 10 MHz.
    input  wire logic             rst_i,       // Synchronous reset, active high.
    input  wire logic [7:0]       opt_byte_i,  // Option byte, sampled after reset release.
    input  wire logic [7:0]       wb_adr_i,    // Wishbone byte address.
    input  wire logic [31:0]      wb_dat_i,    // Wishbone write data.
    input  wire logic [3:0]       wb_sel_i,    // Wishbone byte selects.
    input  wire logic             wb_we_i,     // Wishbone write enable.
    input  wire logic             wb_cyc_i,    // Wishbone cycle.
    input  wire logic             wb_stb_i,    // Wishbone strobe.
    input  wire logic             cpu_bit_op_i, // Current bus write comes from a 1-bit instruction.
    input  wire logic             cpu_fetch_i, // Instruction fetch strobe.
    input  wire logic             cpu_data_i,  // Data read or write strobe.
    input  wire wdw_pkg::wdw_addr_t cpu_addr_i, // CPU address of the fetch or access.
    output logic [31:0]           wb_dat_o,    // Wishbone read data.
    output logic                  wb_ack_o,    // Wishbone acknowledge.
    output logic                  irq_o,       // Level interrupt, unmasked event pending.
    output logic                  rst_req_o    // Internal reset request, held.
);
    import wdw_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wdw_state_t               state;
    wdw_state_t               next_state;
    logic [7:0]               option;
    logic [7:0]               internal_mem_size_reg;
    logic [7:0]               expansion_ram_size_reg;
    logic [`WDW_EV_W-1:0]     status;
    logic [`WDW_EV_W-1:0]     mask;
    logic [`WDW_CNT_W-1:0]    count;
    logic                     kicked_once;
    logic                     tick;
    logic                     req;
    logic                     wr_fire;
    logic                     kick_wr;
    logic                     kick_ok;
    logic                     running;
    logic [2:0]               ovf_sel;
    logic [1:0]               win_sel;
    logic [`WDW_CNT_W-1:0]    period_last;
    logic [`WDW_CNT_W-1:0]    quarter;
    logic [`WDW_CNT_W-1:0]    closed_len;
    logic                     win_open;
    logic                     ovf_hit;
    logic [16:0]              rom_top;
    logic [16:0]              xram_top;
    logic [16:0]              hsram_lo;
    logic [16:0]              addr_x;
    logic                     in_mem;
    logic                     exempt;
    logic [`WDW_EV_W-1:0]     ev_set;
    logic [`WDW_EV_W-1:0]     ev_clr;
    logic [31:0]              rd_data;

    // ****************************************************************
    // Option byte decode
    // ****************************************************************
    assign running = (state == WDW_RUN);
    assign ovf_sel = option[`WDW_OPT_OVF_HI:`WDW_OPT_OVF_LO];
    assign win_sel = option[`WDW_OPT_WIN_HI:`WDW_OPT_WIN_LO];

    // The period is 2^(10+sel) low-speed ticks; the window opens after a closed head.
    assign period_last = (`WDW_CNT_W'(1) << (`WDW_PER_LOG2_BASE + 32'(ovf_sel))) - `WDW_CNT_W'(1);
    assign quarter     = `WDW_CNT_W'(1) << (`WDW_PER_LOG2_BASE - 2 + 32'(ovf_sel));
    always_comb begin
        unique case (win_sel)
            2'b00: closed_len = `WDW_CNT_W'(quarter * `WDW_CNT_W'(3));
            2'b01: closed_len = `WDW_CNT_W'(quarter * `WDW_CNT_W'(2));
            2'b10: closed_len = quarter;
            2'b11: closed_len = '0;
        endcase
    end
    assign win_open = (count >= closed_len);
    assign ovf_hit  = running && tick && (count == period_last);

    // ****************************************************************
    // Low-speed tick source
    // ****************************************************************
    wdw_lso_tick #(
        .DIV       (LSO_DIV)
    ) u_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .restart_i (kick_ok),
        .tick_o    (tick)
    );

    // ****************************************************************
    // Wishbone slave: one wait state, ack for one cycle
    // ****************************************************************
    assign req     = wb_cyc_i && wb_stb_i;
    assign wr_fire = req && wb_we_i && wb_ack_o;
    assign kick_wr = wr_fire && (wb_adr_i == `WDW_ADR_KICK) && wb_sel_i[0] && running;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (wb_adr_i)
            `WDW_ADR_OPTION: rd_data = {24'h00_0000, option};
            `WDW_ADR_IMS:    rd_data = {24'h00_0000, internal_mem_size_reg};
            `WDW_ADR_IXS:    rd_data = {24'h00_0000, expansion_ram_size_reg};
            `WDW_ADR_STATUS: rd_data = {{(32-`WDW_EV_W){1'b0}}, status};
            `WDW_ADR_MASK:   rd_data = {{(32-`WDW_EV_W){1'b0}}, mask};
            `WDW_ADR_COUNT:  rd_data = {{(32-`WDW_CNT_W){1'b0}}, count};
            default:         rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_mem_size_reg <= `WDW_IMS_RST;
            expansion_ram_size_reg <= `WDW_IXS_RST;
        end else if (wr_fire && wb_sel_i[0]) begin
            if (wb_adr_i == `WDW_ADR_IMS) begin
                internal_mem_size_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == `WDW_ADR_IXS) begin
                expansion_ram_size_reg <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask <= '0;
        end else if (wr_fire && wb_sel_i[0] && (wb_adr_i == `WDW_ADR_MASK)) begin
            mask <= wb_dat_i[`WDW_EV_W-1:0];
        end
    end

    // ****************************************************************
    // Start-up: option byte is caught on the first edge after release
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            WDW_LOAD: next_state = opt_byte_i[`WDW_OPT_RUN_BIT] ? WDW_RUN : WDW_OFF;
            WDW_RUN:  next_state = (ev_set != '0) ? WDW_TRIP : WDW_RUN;
            WDW_OFF:  next_state = WDW_OFF;
            WDW_TRIP: next_state = WDW_TRIP;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= WDW_LOAD;
        end else begin
            state <= next_state;
        end
    end

    // The option byte is fixed for the whole run; later strap changes are ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option <= 8'h00;
        end else if (state == WDW_LOAD) begin
            option <= opt_byte_i;
        end
    end

    // ****************************************************************
    // Kick checks
    // ****************************************************************
    always_comb begin
        ev_set  = '0;
        kick_ok = 1'b0;
        if (kick_wr) begin
            if (cpu_bit_op_i) begin
                ev_set[`WDW_EV_BITOP] = 1'b1;
            end else if (wb_dat_i[7:0] != `WDW_KEY) begin
                ev_set[`WDW_EV_KEY] = 1'b1;
            end else if (kicked_once && !win_open) begin
                ev_set[`WDW_EV_WIN] = 1'b1;
            end else begin
                kick_ok = 1'b1;
            end
        end
        // A good kick in the same cycle as the last tick wins over overflow.
        if (ovf_hit && !kick_ok) begin
            ev_set[`WDW_EV_OVF] = 1'b1;
        end
        if (running && cpu_fetch_i && !in_mem) begin
            ev_set[`WDW_EV_FETCH] = 1'b1;
        end
        if (running && cpu_data_i && !in_mem && !exempt) begin
            ev_set[`WDW_EV_DATA] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kicked_once <= 1'b0;
        end else if (kick_ok) begin
            kicked_once <= 1'b1;
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (kick_ok) begin
            count <= '0;
        end else if (running && tick && (count != period_last)) begin
            count <= count + `WDW_CNT_W'(1);
        end
    end

    // ****************************************************************
    // Access check
    // ****************************************************************
    // ROM ends at ims[3:0] * 4 KB, expansion RAM follows for ixs[3:0] * 1 KB,
    // and high-speed RAM sits just below FF00H for ims[7:4] * 256 bytes.
    assign addr_x   = {1'b0, cpu_addr_i};
    assign rom_top  = {1'b0, internal_mem_size_reg[3:0], 12'h000};
    assign xram_top = rom_top + {3'b000, expansion_ram_size_reg[3:0], 10'h000};
    assign hsram_lo = {1'b0, `WDW_HSRAM_END} - {5'b00000, internal_mem_size_reg[7:4], 8'h00};
    assign in_mem   = (addr_x < xram_top) ||
                      ((addr_x >= hsram_lo) && (addr_x < {1'b0, `WDW_HSRAM_END}));
    assign exempt   = ((cpu_addr_i >= `WDW_EXA_LO) && (cpu_addr_i <= `WDW_EXA_HI)) ||
                      (cpu_addr_i >= `WDW_EXB_LO);

    // ****************************************************************
    // Status, interrupt and reset request
    // ****************************************************************
    assign ev_clr = (wr_fire && wb_sel_i[0] && (wb_adr_i == `WDW_ADR_STATUS)) ?
                    wb_dat_i[`WDW_EV_W-1:0] : '0;

    // A new event wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((status & ~ev_clr) | ev_set) & mask);
        end
    end

    // Only a system reset releases the request, so software cannot mask a trip.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_req_o <= 1'b0;
        end else if (ev_set != '0) begin
            rst_req_o <= 1'b1;
        end
    end

endmodule : wdw_top
`default_nettype wire

//--- shared/wdw_consts.svh
// Constants of the windowed watchdog: offsets, fields, reset values and timing counts.
`ifndef WDW_CONSTS_SVH
`define WDW_CONSTS_SVH

// ****************************************************************
// Register byte offsets on the bus
// ****************************************************************
`define WDW_ADR_KICK      8'h00
`define WDW_ADR_OPTION    8'h04
`define WDW_ADR_IMS       8'h08
`define WDW_ADR_IXS       8'h0C
`define WDW_ADR_STATUS    8'h10
`define WDW_ADR_MASK      8'h14
`define WDW_ADR_COUNT     8'h18

// ****************************************************************
// Option byte fields
// ****************************************************************
`define WDW_OPT_RUN_BIT   4
`define WDW_OPT_OVF_HI    3
`define WDW_OPT_OVF_LO    1
`define WDW_OPT_WIN_HI    6
`define WDW_OPT_WIN_LO    5

// ****************************************************************
// Kick key and event bit positions
// ****************************************************************
`define WDW_KEY           8'hAC
`define WDW_EV_OVF        0
`define WDW_EV_KEY        1
`define WDW_EV_BITOP      2
`define WDW_EV_WIN        3
`define WDW_EV_FETCH      4
`define WDW_EV_DATA       5
`define WDW_EV_W          6

// ****************************************************************
// Memory map of the access check and reset values
// ****************************************************************
`define WDW_EXA_LO        16'hFB00
`define WDW_EXA_HI        16'hFFCF
`define WDW_EXB_LO        16'hFFE0
`define WDW_EXB_HI        16'hFFFF
`define WDW_HSRAM_END     16'hFF00
`define WDW_IMS_RST       8'h8C
`define WDW_IXS_RST       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define WDW_CLK_HZ        10000000
`define WDW_LSO_HZ        240000
`define WDW_LSO_DIV       (`WDW_CLK_HZ / `WDW_LSO_HZ)
`define WDW_PER_LOG2_BASE 10
`define WDW_CNT_W         17

`endif

//--- shared/wdw_pkg.sv
// Types shared by the windowed watchdog modules.
package wdw_pkg;

    typedef enum logic [1:0] {
        WDW_LOAD = 2'b00,
        WDW_RUN  = 2'b01,
        WDW_OFF  = 2'b10,
        WDW_TRIP = 2'b11
    } wdw_state_t;

    typedef logic [15:0] wdw_addr_t;

endpackage : wdw_pkg

//--- verilog/wdw_lso_tick.sv
// Low-speed oscillator tick generator for the watchdog counter.
`timescale 1ns/1ps
`default_nettype none
module wdw_lso_tick #(
    parameter int unsigned DIV = 41
) (
    input  wire logic clk_i,     // System clock.
    input  wire logic rst_i,     // Synchronous reset, active high.
    input  wire logic restart_i, // Restart the phase of the tick.
    output logic      tick_o     // One-cycle tick per low-speed period.
);
    import wdw_pkg::*;

    logic [15:0] div_cnt;

    // Restarting the phase on a kick keeps the overflow error below one low-speed period.
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            div_cnt <= 16'h0000;
            tick_o  <= 1'b0;
        end else if (div_cnt == 16'(DIV - 1)) begin
            div_cnt <= 16'h0000;
            tick_o  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            tick_o  <= 1'b0;
        end
    end

endmodule : wdw_lso_tick
`default_nettype wire

//--- dv/wdw_top_props.sv
// Concurrent checks of the windowed watchdog at its top-level ports.
`timescale 1ns/1ps
`default_nettype none
`include "wdw_consts.svh"
module wdw_top_props
    import wdw_pkg::*;
#(
    parameter int unsigned LSO_DIV = 2
) (
    input wire logic        clk_i,        // Clock.
    input wire logic        rst_i,        // Reset.
    input wire logic [7:0]  opt_byte_i,   // Option byte.
    input wire logic [7:0]  wb_adr_i,     // Bus address.
    input wire logic [31:0] wb_dat_i,     // Bus write data.
    input wire logic [3:0]  wb_sel_i,     // Bus selects.
    input wire logic        wb_we_i,      // Bus write.
    input wire logic        wb_cyc_i,     // Bus cycle.
    input wire logic        wb_stb_i,     // Bus strobe.
    input wire logic        cpu_bit_op_i, // Bit-op kick.
    input wire logic        cpu_fetch_i,  // Fetch strobe.
    input wire logic        cpu_data_i,   // Data strobe.
    input wire wdw_addr_t   cpu_addr_i,   // CPU address.
    input wire logic [31:0] wb_dat_o,     // Bus read data.
    input wire logic        wb_ack_o,     // Bus acknowledge.
    input wire logic        irq_o,        // Interrupt.
    input wire logic        rst_req_o     // Reset request.
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // The map below holds only for the size registers at their reset values; the bench never rewrites them.
    logic out_mem;
    logic out_data;
    always_comb begin
        out_mem  = (cpu_addr_i >= 16'hC000 && cpu_addr_i < 16'hF700) || cpu_addr_i >= `WDW_HSRAM_END;
        out_data = out_mem && (cpu_addr_i < `WDW_EXA_LO || cpu_addr_i > `WDW_EXA_HI) && cpu_addr_i < `WDW_EXB_LO;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_live;
        opt_byte_i[`WDW_OPT_RUN_BIT] && !rst_req_o && !$past(rst_i);
    endsequence
    sequence s_kick;
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `WDW_ADR_KICK && wb_sel_i[0] ##0 s_live;
    endsequence
    sequence s_trip;
        ##[1:2] rst_req_o;
    endsequence

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_req_held: assert property (rst_req_o |=> rst_req_o)
        else $error("reset request dropped");
    a_off_quiet: assert property (!opt_byte_i[`WDW_OPT_RUN_BIT] |-> !rst_req_o)
        else $error("reset request while watchdog off");
    a_key_trip: assert property (s_kick ##0 wb_dat_i[7:0] != `WDW_KEY |-> s_trip)
        else $error("wrong key did not trip");
    a_bitop_trip: assert property (s_kick ##0 cpu_bit_op_i |-> s_trip)
        else $error("bit operation kick did not trip");
    a_fetch_trip: assert property (cpu_fetch_i && out_mem ##0 s_live |-> s_trip)
        else $error("bad fetch did not trip");
    a_data_trip: assert property (cpu_data_i && out_data ##0 s_live |-> s_trip)
        else $error("bad data access did not trip");
endmodule : wdw_top_props

bind wdw_top wdw_top_props #(.LSO_DIV(LSO_DIV)) i_wdw_top_props (
    .clk_i(clk_i), .rst_i(rst_i), .opt_byte_i(opt_byte_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .cpu_bit_op_i(cpu_bit_op_i), .cpu_fetch_i(cpu_fetch_i), .cpu_data_i(cpu_data_i),
    .cpu_addr_i(cpu_addr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .rst_req_o(rst_req_o)
);
`default_nettype wire

//--- dv/wdw_top_bench.sv
// Self-checking bench of the windowed watchdog top.
`timescale 1ns/1ps
`default_nettype none
`include "wdw_consts.svh"
module wdw_top_bench;
    import wdw_pkg::*;
    typedef struct {
        logic [7:0] opt;
        logic [1:0] act;
        logic [7:0] kd;
        logic       bop;
        wdw_addr_t  adr;
        logic [7:0] st;
    } wdw_row_t;
    logic        clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, bop = 1'b0;
    logic        fetch = 1'b0, data = 1'b0, ack, irq, rreq;
    logic [7:0]  opt = 8'h10, adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat;
    wdw_addr_t   caddr = 16'h0000;
    int          error_cnt = 0, n_checks = 0;
    wdw_row_t    rows [14] = '{
        '{8'h10, 2'd0, 8'hAC, 1'b0, 16'h0000, 8'h00},
        '{8'h10, 2'd0, 8'h55, 1'b0, 16'h0000, 8'h02},
        '{8'h10, 2'd0, 8'hAC, 1'b1, 16'h0000, 8'h04},
        '{8'h10, 2'd1, 8'h00, 1'b0, 16'hD000, 8'h10},
        '{8'h10, 2'd1, 8'h00, 1'b0, 16'hF6FF, 8'h10},
        '{8'h10, 2'd1, 8'h00, 1'b0, 16'hF700, 8'h00},
        '{8'h10, 2'd1, 8'h00, 1'b0, 16'hBFFF, 8'h00},
        '{8'h10, 2'd2, 8'h00, 1'b0, 16'hC000, 8'h20},
        '{8'h10, 2'd2, 8'h00, 1'b0, 16'hFB00, 8'h00},
        '{8'h10, 2'd2, 8'h00, 1'b0, 16'hFFCF, 8'h00},
        '{8'h10, 2'd2, 8'h00, 1'b0, 16'hFFD0, 8'h20},
        '{8'h10, 2'd2, 8'h00, 1'b0, 16'hFFE0, 8'h00},
        '{8'h00, 2'd0, 8'h55, 1'b0, 16'h0000, 8'h00},
        '{8'h00, 2'd1, 8'h00, 1'b0, 16'hD000, 8'h00}
    };

    always #50 clk = ~clk;

    wdw_top #(.LSO_DIV(2)) i_wdw_top (
        .clk_i(clk), .rst_i(rst), .opt_byte_i(opt), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .cpu_bit_op_i(bop), .cpu_fetch_i(fetch),
        .cpu_data_i(data), .cpu_addr_i(caddr), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .rst_req_o(rreq)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic b,
                      output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        bop <= b;
        // Ack and read data are taken at the very rising edge that samples ack high, then released.
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        bop <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, 1'b0, q);
        chk(q, exp, msg);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(a, 1'b1, {24'h0, d}, 1'b0, q);
    endtask : wr

    task automatic kick(input logic [7:0] d, input logic b);
        logic [31:0] q;
        wb(`WDW_ADR_KICK, 1'b1, {24'h0, d}, b, q);
    endtask : kick

    task automatic cpu(input logic f, input wdw_addr_t a);
        @(posedge clk);
        fetch <= f;
        data <= !f;
        caddr <= a;
        @(posedge clk);
        fetch <= 1'b0;
        data <= 1'b0;
    endtask : cpu

    task automatic boot(input logic [7:0] o);
        @(posedge clk);
        rst <= 1'b1;
        opt <= o;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : boot

    task automatic settle(input logic [7:0] st, input string msg);
        repeat (3) @(posedge clk);
        rd(`WDW_ADR_STATUS, {24'h0, st}, msg);
        @(negedge clk);
        chk({31'h0, rreq}, {31'h0, st != 8'h00}, "reset request");
    endtask : settle

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        logic [31:0] q;
        boot(8'h10);
        rd(`WDW_ADR_IMS, 32'h8C, "ims reset");
        rd(`WDW_ADR_IXS, 32'h00, "ixs reset");
        rd(`WDW_ADR_MASK, 32'h00, "mask reset");
        rd(8'h1C, 32'h00, "unmapped");
        wr(`WDW_ADR_OPTION, 8'hFF);
        rd(`WDW_ADR_OPTION, 32'h10, "option read-only");
        foreach (rows[i]) begin
            boot(rows[i].opt);
            case (rows[i].act)
                2'd0: kick(rows[i].kd, rows[i].bop);
                default: cpu(rows[i].act == 2'd1, rows[i].adr);
            endcase
            settle(rows[i].st, "row status");
        end
        boot(8'h10);
        kick(8'h55, 1'b0);
        settle(8'h02, "bad key");
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(`WDW_ADR_MASK, 8'h02);
        repeat (3) @(negedge clk);
        chk({31'h0, irq}, 32'h1, "unmasked irq");
        wr(`WDW_ADR_STATUS, 8'h02);
        rd(`WDW_ADR_STATUS, 32'h0, "status cleared");
        repeat (3) @(negedge clk);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        boot(8'h10);
        kick(8'hAC, 1'b0);
        kick(8'hAC, 1'b0);
        settle(8'h08, "closed window");
        boot(8'h70);
        kick(8'hAC, 1'b0);
        kick(8'hAC, 1'b0);
        settle(8'h00, "always open");
        // The late kick lands a few ticks short of overflow, well outside the two-tick tolerance.
        boot(8'h10);
        kick(8'hAC, 1'b0);
        repeat (2030) @(posedge clk);
        kick(8'hAC, 1'b0);
        wb(`WDW_ADR_COUNT, 1'b0, 32'h0, 1'b0, q);
        chk({31'h0, q < 32'd4}, 32'h1, "count restart");
        settle(8'h00, "late kick");
        repeat (2024) @(posedge clk);
        @(negedge clk);
        chk({31'h0, rreq}, 32'h0, "early overflow");
        repeat (24) @(posedge clk);
        settle(8'h01, "overflow");
        boot(8'h12);
        repeat (4080) @(posedge clk);
        @(negedge clk);
        chk({31'h0, rreq}, 32'h0, "period select");
        repeat (32) @(posedge clk);
        settle(8'h01, "long overflow");
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule : wdw_top_bench
`default_nettype wire
